// ### logic/buffered_host_access_cycle.sv
`timescale 1ns/100ps
`include "host_access_map.svh"

module buffered_host_access_cycle #(
	parameter int ADDR_W = `HA_ADDR_W,
	parameter int DATA_W = `HA_DATA_W
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hostSelectN,
	input wire logic host_strobe_n,
	input wire logic spaceSelect,
	input wire logic hostDirection,
	input wire logic [ADDR_W-1:0] host_address_bus,
	input wire logic [DATA_W-1:0] hostDataIn,
	output logic [DATA_W-1:0] hostDataOut,
	output logic hostDataOeN,
	output logic access_grant_n,
	output logic transfer_done_n,
	input wire logic latch_mode_strap,
	input wire logic waitModeStrap,
	input wire logic bus_width_strap,
	input wire logic address_latch_strap,
	input wire logic directionSenseStrap,
	input wire logic triggerSelStrap,
	input wire logic byteOrderStrap,
	output logic configOk,
	input wire logic ramBusy,
	output logic hostHold,
	output logic memReq,
	output logic memWrite,
	output logic memSpace,
	output logic [ADDR_W-1:0] memAddr,
	output logic [DATA_W-1:0] memWrData,
	input wire logic [DATA_W-1:0] memRdData,
	input wire logic memAck
);
	import host_access_pkg::*;

	localparam int BUS_W = ADDR_W + DATA_W;
	localparam logic [`HA_CTL_W-1:0] CTL_RST = {1'b0, 1'b0, `HA_STROBE_IDLE, `HA_STROBE_IDLE};

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [`HA_CTL_W-1:0] ctlS;
	logic [BUS_W-1:0] busS;
	logic busSettling;
	logic [4:0] strapS;
	logic selS;
	logic strbS;
	logic spaceS;
	logic dirS;
	logic [ADDR_W-1:0] addrS;
	logic [DATA_W-1:0] dataS;

	// Every host pin is asynchronous to mclk
	pin_sync #(.WIDTH(`HA_CTL_W), .RST_VAL(CTL_RST)) u_ctl_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pinIn({hostDirection, spaceSelect, host_strobe_n, hostSelectN}),
		.stable(ctlS),
		.settling()
	);

	pin_sync #(.WIDTH(BUS_W), .RST_VAL('0)) u_bus_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pinIn({host_address_bus, hostDataIn}),
		.stable(busS),
		.settling(busSettling)
	);

	pin_sync #(.WIDTH(5), .RST_VAL('0)) u_strap_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pinIn({directionSenseStrap, address_latch_strap, bus_width_strap,
			waitModeStrap, latch_mode_strap}),
		.stable(strapS),
		.settling()
	);

	// Control and bus fields
	assign selS = ctlS[`HA_CTL_SEL];
	assign strbS = ctlS[`HA_CTL_STRB];
	assign spaceS = ctlS[`HA_CTL_SPACE];
	assign dirS = ctlS[`HA_CTL_DIR];
	assign addrS = busS[BUS_W-1:DATA_W];
	assign dataS = busS[DATA_W-1:0];

	// ****************************************
	// Strap capture
	// ****************************************
	logic [2:0] strapAge;
	logic dirSense;
	logic [2:0] next_strapAge;
	logic next_configOk;
	logic next_dirSense;

	// Straps are caught once; earlier the synchroniser still shows its reset zeros
	always_comb begin
		next_strapAge = strapAge;
		next_configOk = configOk;
		next_dirSense = dirSense;
		if (strapAge != `HA_STRAP_AGE_MAX) begin
			next_strapAge = strapAge + 3'h1;
		end
		if (strapAge == `HA_STRAP_CAPTURE) begin
			// Trigger select and byte order take no part in the check
			next_configOk = (strapS[0] == `HA_LATCH_MODE_REQ) && (strapS[1] == `HA_WAIT_MODE_REQ)
				&& (strapS[2] == `HA_BUS_WIDTH_REQ) && (strapS[3] == `HA_ADDR_LATCH_REQ);
			next_dirSense = strapS[4];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			strapAge <= 3'h0;
			configOk <= 1'b0;
			dirSense <= 1'b0;
		end else begin
			strapAge <= next_strapAge;
			configOk <= next_configOk;
			dirSense <= next_dirSense;
		end
	end

	// ****************************************
	// Access cycle
	// ****************************************
	cycle_state_t state;
	cycle_state_t next_state;
	logic next_grantN;
	logic next_doneN;
	logic next_oeN;
	logic next_hostHold;
	logic next_memReq;
	logic next_memWrite;
	logic next_memSpace;
	logic [ADDR_W-1:0] next_memAddr;
	logic [DATA_W-1:0] next_memWrData;
	logic [DATA_W-1:0] next_hostDataOut;

	// One cycle per grant; a mis-strapped part never grants, so it cannot corrupt RAM
	always_comb begin
		next_state = state;
		next_grantN = access_grant_n;
		next_doneN = transfer_done_n;
		next_oeN = hostDataOeN;
		next_hostHold = hostHold;
		next_memReq = memReq;
		next_memWrite = memWrite;
		next_memSpace = memSpace;
		next_memAddr = memAddr;
		next_memWrData = memWrData;
		next_hostDataOut = hostDataOut;
		case (state)
			ST_IDLE: begin
				// Tied select and strobe look the same here
				if (configOk && !selS && !strbS && !ramBusy) begin
					next_grantN = 1'b0;
					next_hostHold = 1'b1;
					next_state = ST_CTL;
				end
			end
			ST_CTL: begin
				next_memSpace = spaceS;
				next_memWrite = dirS ^ dirSense;
				if (busSettling) begin
					next_state = ST_XTRA;
				end else begin
					next_memAddr = addrS;
					next_memWrData = dataS;
					next_memReq = 1'b1;
					next_state = ST_MEM;
				end
			end
			ST_XTRA: begin
				next_memAddr = addrS;
				next_memWrData = dataS;
				next_memReq = 1'b1;
				next_state = ST_MEM;
			end
			ST_MEM: begin
				if (memAck) begin
					next_memReq = 1'b0;
					next_hostDataOut = memRdData;
					next_oeN = memWrite;
					next_doneN = 1'b0;
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				// No timeout: the host may wait as long as it likes
				if (strbS) begin
					next_grantN = 1'b1;
					next_doneN = 1'b1;
					next_oeN = 1'b1;
					next_hostHold = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_grantN = 1'b1;
				next_doneN = 1'b1;
				next_oeN = 1'b1;
				next_hostHold = 1'b0;
				next_memReq = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= ST_IDLE;
			access_grant_n <= `HA_STROBE_IDLE;
			transfer_done_n <= `HA_STROBE_IDLE;
			hostDataOeN <= 1'b1;
			hostHold <= 1'b0;
			memReq <= 1'b0;
			memWrite <= 1'b0;
			memSpace <= 1'b0;
			memAddr <= `HA_ADDR_RST;
			memWrData <= `HA_DATA_RST;
			hostDataOut <= `HA_DATA_RST;
		end else begin
			state <= next_state;
			access_grant_n <= next_grantN;
			transfer_done_n <= next_doneN;
			hostDataOeN <= next_oeN;
			hostHold <= next_hostHold;
			memReq <= next_memReq;
			memWrite <= next_memWrite;
			memSpace <= next_memSpace;
			memAddr <= next_memAddr;
			memWrData <= next_memWrData;
			hostDataOut <= next_hostDataOut;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_grant_cause;
		$fell(access_grant_n) |-> $past(configOk && !selS && !strbS && !ramBusy);
	endproperty
	a_grant_cause: assert property (p_grant_cause) else $error("grant without request");

	property p_sync_delay;
		(access_grant_n && $fell(host_strobe_n)) |-> access_grant_n [*3];
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("grant beat synchroniser");

	property p_space_latch;
		$fell(access_grant_n) |-> ##2 (memSpace == $past(spaceS));
	endproperty
	a_space_latch: assert property (p_space_latch) else $error("space not latched");

	property p_dir_sense;
		$fell(access_grant_n) |-> ##2 (memWrite == ($past(dirS) ^ dirSense));
	endproperty
	a_dir_sense: assert property (p_dir_sense) else $error("bad write sense");

	property p_addr_latch;
		$rose(memReq) |-> (memAddr == $past(addrS)) && (memWrData == $past(dataS));
	endproperty
	a_addr_latch: assert property (p_addr_latch) else $error("bus not latched");

	property p_extra_clock;
		(state == ST_CTL && busSettling) |=> !memReq ##1 memReq;
	endproperty
	a_extra_clock: assert property (p_extra_clock) else $error("extra clock wrong");

	property p_close;
		(state == ST_DONE && strbS) |=> access_grant_n && transfer_done_n && !hostHold;
	endproperty
	a_close: assert property (p_close) else $error("cycle not closed");

	property p_hold_off;
		!access_grant_n |-> hostHold;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("RAM not held off");

	property p_done_after_ack;
		(memReq && memAck) |=> !transfer_done_n && !memReq && !access_grant_n;
	endproperty
	a_done_after_ack: assert property (p_done_after_ack) else $error("done missing");

	c_write: cover property ($fell(transfer_done_n) && memWrite);
	c_read: cover property ($fell(transfer_done_n) && !memWrite && !hostDataOeN);
	c_extra: cover property (state == ST_XTRA);
	c_contended: cover property (state == ST_IDLE && !selS && !strbS && ramBusy);

endmodule : buffered_host_access_cycle

// ### logic/host_access_map.svh
`ifndef HOST_ACCESS_MAP_SVH
`define HOST_ACCESS_MAP_SVH

// Bus widths of the host port
`define HA_ADDR_W 16
`define HA_DATA_W 16

// Strap levels that select the 16-bit buffered nonzero-wait cycle
`define HA_LATCH_MODE_REQ 1'b0
`define HA_WAIT_MODE_REQ 1'b1
`define HA_BUS_WIDTH_REQ 1'b1
`define HA_ADDR_LATCH_REQ 1'b1

// Reset values of the active-low outputs and of the data and address buses
`define HA_STROBE_IDLE 1'b1
`define HA_DATA_RST 16'h0000
`define HA_ADDR_RST 16'h0000

// Strap capture: the synchronised straps lag the pins by four edges after reset
`define HA_STRAP_CAPTURE 3'h4
`define HA_STRAP_AGE_MAX 3'h7

// Bit positions inside the synchronised control group
`define HA_CTL_SEL 0
`define HA_CTL_STRB 1
`define HA_CTL_SPACE 2
`define HA_CTL_DIR 3
`define HA_CTL_W 4

`endif

// ### logic/host_access_pkg.sv
package host_access_pkg;

	// Cycle states, Gray coded along the path from ST_IDLE through ST_XTRA to ST_DONE
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CTL = 3'b001,
		ST_XTRA = 3'b011,
		ST_MEM = 3'b010,
		ST_DONE = 3'b110
	} cycle_state_t;

endpackage : host_access_pkg

// ### logic/pin_sync.sv
`timescale 1ns/100ps

// ****************************************
// Three-stage pin synchroniser
// ****************************************
module pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] stable,
	output logic settling
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_stable;
	logic next_settling;

	// A bit only moves once stages two and three agree on it
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_stable[i] = (s2[i] == s3[i]) ? s3[i] : stable[i];
		end
		next_settling = (s2 != s3);
	end

	// s1 feeds s2 only; it may be metastable
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			stable <= RST_VAL;
			settling <= 1'b0;
		end else begin
			s1 <= pinIn;
			s2 <= s1;
			s3 <= s2;
			stable <= next_stable;
			settling <= next_settling;
		end
	end

endmodule : pin_sync

// ### bench/host_model.sv
`timescale 1ns/100ps

// ****************************************
// Host processor on the parallel port
// ****************************************
module host_model (
	input wire logic mclk,
	output logic selN,
	output logic strbN,
	output logic space,
	output logic dir,
	output logic [15:0] addr,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic grantN,
	input wire logic doneN
);
	initial begin
		selN = 1'b1;
		strbN = 1'b1;
		space = 1'b0;
		dir = 1'b0;
		addr = 16'h0000;
		wdata = 16'h0000;
	end

	// One access; tie keeps select and strobe moving as one line
	task automatic access(input logic sp, input logic dr, input logic [15:0] a,
		input logic [15:0] d, input logic tie, input int lag, output logic [15:0] q);
		int n;
		@(posedge mclk);
		selN <= 1'b0;
		strbN <= 1'b0;
		space <= sp;
		dir <= dr;
		// A bus that goes valid late makes the port insert its extra clock
		repeat (lag) @(posedge mclk);
		addr <= a;
		wdata <= d;
		for (n = 0; n < 60 && grantN !== 1'b0; n++) @(posedge mclk);
		// Select may go only once the grant is seen
		if (!tie) selN <= 1'b1;
		// Buses held until done, longer than the extra clock needs
		for (n = 0; n < 60 && doneN !== 1'b0; n++) @(posedge mclk);
		q = rdata;
		strbN <= 1'b1;
		selN <= 1'b1;
		// Released lines flip so a stale value cannot pass
		addr <= ~a;
		wdata <= ~d;
		space <= ~sp;
		dir <= ~dr;
		for (n = 0; n < 60 && grantN !== 1'b1; n++) @(posedge mclk);
	endtask : access
endmodule : host_model

// ### bench/testbench.sv
`timescale 1ns/100ps

module testbench;
	logic mclk, rstn, sense, ramBusy, memAck, trig, bord, lm, wm, bw, al;
	logic selN, strbN, space, dir, oeN, grantN, doneN, cfgOk, hold, memReq, memWrite, memSpace;
	logic sW, sS, oeDone;
	logic [15:0] addr, wdata, rdata, memAddr, memWrData, rdPat, sA, sD, q, gdCnt;
	int n_errors = 0, num_checks = 0, ackDelay = 0, wt = 0;

	host_model host_u (.mclk(mclk), .selN(selN), .strbN(strbN), .space(space), .dir(dir),
		.addr(addr), .wdata(wdata), .rdata(rdata), .grantN(grantN), .doneN(doneN));
	buffered_host_access_cycle dut_u (.mclk(mclk), .rstn(rstn), .hostSelectN(selN),
		.host_strobe_n(strbN), .spaceSelect(space), .hostDirection(dir),
		.host_address_bus(addr), .hostDataIn(wdata), .hostDataOut(rdata),
		.hostDataOeN(oeN), .access_grant_n(grantN), .transfer_done_n(doneN),
		.latch_mode_strap(lm), .waitModeStrap(wm), .bus_width_strap(bw),
		.address_latch_strap(al), .directionSenseStrap(sense), .triggerSelStrap(trig),
		.byteOrderStrap(bord), .configOk(cfgOk), .ramBusy(ramBusy), .hostHold(hold),
		.memReq(memReq), .memWrite(memWrite), .memSpace(memSpace), .memAddr(memAddr),
		.memWrData(memWrData), .memRdData(rdPat), .memAck(memAck));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// RAM side answers after ackDelay cycles and records what it was handed
	always @(posedge mclk) begin
		wt <= memReq ? wt + 1 : 0;
		memAck <= memReq && !memAck && wt == ackDelay;
		if (memReq && memAck) begin
			{sW, sS, sA, sD} <= {memWrite, memSpace, memAddr, memWrData};
		end
	end

	// Clocks from grant to done, and the drive enable seen while done stands
	always @(posedge mclk) begin
		gdCnt <= grantN ? 16'h0000 : gdCnt + {15'h0000, doneN};
		if (doneN === 1'b0) oeDone <= oeN;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rst_dut();
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask : rst_dut

	// Write pin level depends on the sense strap
	task automatic wr(input logic sp, input logic [15:0] a, input logic [15:0] d);
		host_u.access(sp, ~sense, a, d, 1'b0, 0, q);
	endtask : wr

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		#200000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		{rstn, sense, ramBusy, trig, bord, lm, wm, bw, al} = 9'b000000111;
		rdPat = 16'h0000;
		rst_dut();
		chk("cfgOk", 16'h0001, {15'h0000, cfgOk});
		wr(1'b1, 16'h1234, 16'habcd);
		chk("wAddr", 16'h1234, sA);
		chk("wData", 16'habcd, sD);
		chk("wCtl", 16'h0003, {14'h0000, sW, sS});
		chk("closed", 16'h0001, {14'h0000, hold, doneN});
		chk("wSpan", 16'h0003, gdCnt);
		chk("wOeN", 16'h0001, {15'h0000, oeDone});
		$display("Test write done");
		// Address and data valid two clocks after strobe: one extra clock
		host_u.access(1'b1, ~sense, 16'h0f0f, 16'h3c3c, 1'b0, 2, q);
		chk("xAddr", 16'h0f0f, sA);
		chk("xData", 16'h3c3c, sD);
		chk("xSpan", 16'h0004, gdCnt);
		$display("Test extra clock done");
		// Tied select and strobe, slow RAM, other straps flipped
		rdPat <= 16'h5a3c;
		ackDelay <= 3;
		trig <= 1'b1;
		bord <= 1'b1;
		host_u.access(1'b0, sense, 16'h00f0, 16'h0000, 1'b1, 0, q);
		chk("rData", 16'h5a3c, q);
		chk("rOeN", 16'h0000, {15'h0000, oeDone});
		chk("rSpan", 16'h0006, gdCnt);
		chk("rCtl", 16'h0000, {14'h0000, sW, sS});
		chk("oeN", 16'h0001, {15'h0000, oeN});
		$display("Test read done");
		// Busy RAM holds off the grant
		ramBusy <= 1'b1;
		fork
			wr(1'b1, 16'hfffe, 16'h0001);
			begin
				repeat (12) @(posedge mclk);
				chk("busyGrant", 16'h0001, {15'h0000, grantN});
				ramBusy <= 1'b0;
			end
		join
		chk("busyAddr", 16'hfffe, sA);
		$display("Test contention done");
		// Opposite direction sense after a reset in mid-run
		sense <= 1'b1;
		ackDelay = 0;
		rst_dut();
		wr(1'b1, 16'h8001, 16'h7ffe);
		chk("senseW", 16'h0001, {15'h0000, sW});
		chk("senseD", 16'h7ffe, sD);
		$display("Test sense done");
		// Illegal straps never grant
		lm <= 1'b1;
		rst_dut();
		chk("badCfg", 16'h0000, {15'h0000, cfgOk});
		fork
			wr(1'b1, 16'h0101, 16'h0202);
			begin
				repeat (12) @(posedge mclk);
				chk("badGrant", 16'h0001, {15'h0000, grantN});
			end
		join
		chk("badHold", 16'h0000, {15'h0000, hold});
		$display("Test straps done");
		tally_and_finish();
	end
endmodule : testbench
